/* core/accel_background_task_scheduler.sv */
// Task scheduler of the control accelerator with optional background task 8.
// Assumes the accelerator core reports task end, its current PC and a
// non-preemptible region flag, all synchronous to pclk.
// Register offsets and field positions are those of sched_pkg.
`timescale 1ns/1ns
`default_nettype none
module accel_background_task_scheduler #(
    parameter int PC_W = sched_pkg::PC_W_DEF,
    parameter int RESULT_W = sched_pkg::RESULT_W_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sched_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] task_trigger,
    input wire logic task_done,
    input wire logic bg_terminate,
    input wire logic no_preempt_region,
    input wire logic [PC_W-1:0] accel_pc,
    output logic pc_load,
    output logic [PC_W-1:0] pc_load_value,
    output logic task_start,
    output logic [3:0] active_task,
    output logic bg_running,
    input wire logic conv_done,
    input wire logic [RESULT_W-1:0] conv_result,
    output logic [RESULT_W-1:0] result_data
);
    import sched_pkg::*;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    sched_state_t state_r;
    logic bg_en_r;
    logic [PC_W-1:0] vec_r [0:NUM_TASKS-1];
    logic [PC_W-1:0] bg_vec_r;
    logic [PC_W-1:0] resume_r;
    logic [RESULT_W-1:0] result_r;
    logic [7:0] pending_r;
    logic bg_live_r;
    logic bg_preempted_r;
    logic pc_load_r;
    logic [PC_W-1:0] pc_val_r;
    logic task_start_r;
    logic [3:0] active_r;
    logic [31:0] prdata_r;
    logic err_r;

    logic wr_en;
    logic setup;
    logic soft_term;
    logic term_req;
    logic [7:0] pick_req;
    logic pick_found;
    logic [2:0] pick_idx;
    logic launch_go;
    logic resume_go;
    logic end_bg;
    logic save_resume;
    logic [7:0] launch_mask;
    logic [31:0] rd_mux;
    logic rd_err;
    logic [RESULT_W-1:0] result_now;

    assign wr_en = psel && penable && pwrite;
    assign setup = psel && !penable;
    assign soft_term = wr_en && (paddr == OFS_BG_CTRL) && pwdata[CTRL_TERM_BIT];
    assign term_req = bg_terminate || soft_term;

    // ------------------------------------------------------------------
    // Vector register decode, shared by the write and read paths
    // ------------------------------------------------------------------
    function automatic logic is_vec_addr(input logic [PADDR_W-1:0] a);
        return a >= OFS_VEC_FIRST && a <= OFS_VEC_LAST && a[1:0] == 2'b00;
    endfunction

    function automatic logic [2:0] vec_index(input logic [PADDR_W-1:0] a);
        logic [PADDR_W-1:0] word;
        word = (a - OFS_VEC_FIRST) >> 2;
        return word[2:0];
    endfunction

    // ------------------------------------------------------------------
    // Task selection
    // ------------------------------------------------------------------
    // Task 8 requests stay pending but are not picked while the background task is alive
    assign pick_req = pending_r & (bg_live_r ? 8'h7f : 8'hff);

    task_priority_pick #(
        .N(NUM_TASKS)
    ) u_pick (
        .req(pick_req),
        .found(pick_found),
        .idx(pick_idx)
    );

    always_comb begin
        launch_go = 1'b0;
        resume_go = 1'b0;
        end_bg = 1'b0;
        save_resume = 1'b0;
        case (state_r)
            ST_IDLE: begin
                launch_go = pick_found;
            end
            ST_FG: begin
                if (task_done) begin
                    if (pick_found) begin
                        launch_go = 1'b1;
                    end else if (bg_live_r && !term_req) begin
                        // A background task retired in this cycle is not resumed
                        resume_go = 1'b1;
                    end
                end
            end
            ST_BG: begin
                // Terminate and self-end win over any pending preemption
                if (term_req || task_done) begin
                    end_bg = 1'b1;
                end else if ((|pending_r[6:0]) && !no_preempt_region) begin
                    launch_go = 1'b1;
                    save_resume = 1'b1;
                end
            end
            default: begin
                launch_go = 1'b0;
            end
        endcase
    end

    // One-hot clear of the launched task's pending bit
    assign launch_mask = launch_go ? (8'h01 << pick_idx) : 8'h00;

    // ------------------------------------------------------------------
    // Pending triggers; a new trigger beats the clear of a launch
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_r <= 8'h00;
        end else begin
            pending_r <= (pending_r & ~launch_mask) | task_trigger;
        end
    end

    // ------------------------------------------------------------------
    // Scheduler state and core controls
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            bg_live_r <= 1'b0;
            bg_preempted_r <= 1'b0;
            pc_load_r <= 1'b0;
            pc_val_r <= '0;
            task_start_r <= 1'b0;
            active_r <= NO_TASK;
        end else begin
            pc_load_r <= 1'b0;
            task_start_r <= 1'b0;
            if (launch_go) begin
                pc_load_r <= 1'b1;
                task_start_r <= 1'b1;
                active_r <= 4'({1'b0, pick_idx} + 4'h1);
                if (pick_idx == 3'h7 && bg_en_r) begin
                    pc_val_r <= bg_vec_r;
                    state_r <= ST_BG;
                    bg_live_r <= 1'b1;
                    bg_preempted_r <= 1'b0;
                end else begin
                    pc_val_r <= vec_r[pick_idx];
                    state_r <= ST_FG;
                    if (save_resume) begin
                        bg_preempted_r <= 1'b1;
                    end
                end
            end else if (resume_go) begin
                pc_load_r <= 1'b1;
                pc_val_r <= resume_r;
                state_r <= ST_BG;
                active_r <= 4'h8;
                bg_preempted_r <= 1'b0;
            end else if (end_bg) begin
                state_r <= ST_IDLE;
                bg_live_r <= 1'b0;
                bg_preempted_r <= 1'b0;
                active_r <= NO_TASK;
            end else if (state_r == ST_FG && task_done) begin
                state_r <= ST_IDLE;
                active_r <= NO_TASK;
            end
            // A terminate while the background task is preempted retires it,
            // so the foreground task then ends in idle rather than resuming
            if (state_r == ST_FG && bg_live_r && term_req) begin
                bg_live_r <= 1'b0;
                bg_preempted_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Resume address capture on preemption
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resume_r <= PC_W'(RST_RESUME);
        end else if (save_resume) begin
            resume_r <= accel_pc;
        end
    end

    // ------------------------------------------------------------------
    // Converter result with same-cycle bypass
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_r <= RESULT_W'(RST_RESULT);
        end else if (conv_done) begin
            result_r <= conv_result;
        end
    end

    assign result_now = conv_done ? conv_result : result_r;

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // Writes land on the access edge; read-only offsets ignore them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bg_en_r <= RST_BG_EN;
            bg_vec_r <= PC_W'(RST_VEC);
            for (int i = 0; i < NUM_TASKS; i++) begin
                vec_r[i] <= PC_W'(RST_VEC);
            end
        end else if (wr_en) begin
            if (paddr == OFS_BG_CTRL) begin
                bg_en_r <= pwdata[CTRL_BG_EN_BIT];
            end else if (paddr == OFS_BG_VEC) begin
                bg_vec_r <= pwdata[PC_W-1:0];
            end else if (is_vec_addr(paddr)) begin
                vec_r[vec_index(paddr)] <= pwdata[PC_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        if (paddr == OFS_BG_CTRL) begin
            rd_mux[CTRL_BG_EN_BIT] = bg_en_r;
        end else if (paddr == OFS_BG_VEC) begin
            rd_mux[PC_W-1:0] = bg_vec_r;
        end else if (paddr == OFS_BG_RESUME) begin
            rd_mux[PC_W-1:0] = resume_r;
        end else if (paddr == OFS_STATUS) begin
            rd_mux[ST_TASK_LSB +: 4] = active_r;
            rd_mux[ST_BG_LIVE_BIT] = bg_live_r;
            rd_mux[ST_BG_PREEMPT_BIT] = bg_preempted_r;
            rd_mux[ST_PEND_LSB +: 8] = pending_r;
        end else if (paddr == OFS_RESULT) begin
            rd_mux[RESULT_W-1:0] = result_now;
        end else if (is_vec_addr(paddr)) begin
            rd_mux[PC_W-1:0] = vec_r[vec_index(paddr)];
        end else begin
            rd_err = 1'b1;
        end
    end

    // Read data and error are captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            err_r <= 1'b0;
        end else if (setup) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
            err_r <= rd_err;
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    // Error flag only shows in the access phase
    assign pslverr = psel && penable && err_r;
    assign pc_load = pc_load_r;
    assign pc_load_value = pc_val_r;
    assign task_start = task_start_r;
    assign active_task = active_r;
    assign bg_running = (state_r == ST_BG);
    assign result_data = result_now;

endmodule // accel_background_task_scheduler
`default_nettype wire

/* core/sched_pkg.sv */
// Constants, register map and field layout of the background task scheduler.
// Assumes a single 50 MHz pclk domain and an APB register port.
`default_nettype none
package sched_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_TASKS = 8;
    localparam int PC_W_DEF = 16;
    localparam int RESULT_W_DEF = 16;
    localparam int PADDR_W = 12;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [PADDR_W-1:0] OFS_BG_CTRL = 12'h000;
    localparam logic [PADDR_W-1:0] OFS_VEC_FIRST = 12'h004;
    localparam logic [PADDR_W-1:0] OFS_VEC_LAST = 12'h020;
    localparam logic [PADDR_W-1:0] OFS_BG_VEC = 12'h024;
    localparam logic [PADDR_W-1:0] OFS_BG_RESUME = 12'h028;
    localparam logic [PADDR_W-1:0] OFS_STATUS = 12'h02c;
    localparam logic [PADDR_W-1:0] OFS_RESULT = 12'h030;

    // ------------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------------
    localparam int CTRL_BG_EN_BIT = 0;
    localparam int CTRL_TERM_BIT = 1;
    localparam int ST_TASK_LSB = 0;
    localparam int ST_BG_LIVE_BIT = 4;
    localparam int ST_BG_PREEMPT_BIT = 5;
    localparam int ST_PEND_LSB = 8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic RST_BG_EN = 1'b0;
    localparam logic [31:0] RST_VEC = 32'h0000_0000;
    localparam logic [31:0] RST_RESUME = 32'h0000_0000;
    localparam logic [31:0] RST_RESULT = 32'h0000_0000;
    localparam logic [3:0] NO_TASK = 4'h0;

    typedef enum {ST_IDLE, ST_FG, ST_BG} sched_state_t;

endpackage
`default_nettype wire

/* core/task_priority_pick.sv */
// Priority picker: lowest set request bit wins (bit 0 is task 1).
// Assumes purely combinational use inside the scheduler.
`timescale 1ns/1ns
`default_nettype none
module task_priority_pick #(
    parameter int N = 8
) (
    input wire logic [N-1:0] req,
    output logic found,
    output logic [2:0] idx
);
    import sched_pkg::*;

    always_comb begin
        found = 1'b0;
        idx = 3'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx = 3'(i);
            end
        end
    end

endmodule // task_priority_pick
`default_nettype wire

/* tb/accel_background_task_scheduler_test.sv */
// Self-checking bench for the background task scheduler.
// Assumes the core model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module accel_background_task_scheduler_test;
    import sched_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, bg_terminate, no_preempt_region;
    logic task_done, fin, conv_done, pready, pslverr, pc_load, task_start, bg_running, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0] task_trigger;
    logic [3:0] active_task;
    logic [15:0] accel_pc, pc_load_value, conv_result, result_data, pcs, rp;
    int mismatches, check_count;

    accel_background_task_scheduler dut_u (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .task_trigger,
        .task_done, .bg_terminate, .no_preempt_region, .accel_pc, .pc_load,
        .pc_load_value, .task_start, .active_task, .bg_running, .conv_done,
        .conv_result, .result_data);
    accel_core_model core_u (.pclk, .presetn, .pc_load, .pc_load_value,
        .finish(fin), .accel_pc, .task_done);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            mismatches++;
            $display("mismatch at %0t: saw %h want %h", $time, s, x);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic trig(input logic [7:0] t);
        @(posedge pclk);
        task_trigger <= t;
        @(posedge pclk);
        task_trigger <= 8'h00;
    endtask

    task automatic finish_task();
        @(posedge pclk);
        fin <= 1'h1;
        @(posedge pclk);
        fin <= 1'h0;
    endtask

    // Waits for a launch; pcs holds the counter sampled at the launch edge
    task automatic wait_load();
        int n;
        n = 0;
        #1;
        do begin
            pcs = accel_pc;
            tick(1);
            n++;
        end while (pc_load !== 1'h1 && n < 40);
        check(pc_load, 1'h1);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_regs();
        apb(1'h0, OFS_STATUS, 32'h0);
        check(r, 32'h0);
        for (int n = 1; n <= 9; n++) begin
            apb(1'h1, 12'(4 * n), 32'hffff_a000 + n);
            apb(1'h0, 12'(4 * n), 32'h0);
            check(r, 32'ha000 + n);
        end
        apb(1'h1, OFS_BG_RESUME, 32'h1234);
        apb(1'h0, OFS_BG_RESUME, 32'h0);
        check({r[30:0], e}, 32'h0);
        apb(1'h1, 12'h040, 32'h1);
        check(e, 1'h1);
    endtask

    task automatic s_plain();
        trig(8'h80);
        wait_load();
        check({bg_running, active_task, pc_load_value}, {5'h08, 16'ha008});
        finish_task();
        tick(4);
        check(active_task, 4'h0);
    endtask

    task automatic s_background();
        apb(1'h1, OFS_BG_CTRL, 32'h1);
        trig(8'h80);
        wait_load();
        check({bg_running, pc_load_value}, {1'h1, 16'ha009});
        tick(20);
        apb(1'h0, OFS_STATUS, 32'h0);
        check(r, 32'h18);
        trig(8'h06);
        wait_load();
        rp = pcs;
        check({bg_running, active_task, pc_load_value}, {5'h02, 16'ha002});
        apb(1'h0, OFS_BG_RESUME, 32'h0);
        check(r, {16'h0, rp});
        apb(1'h0, OFS_STATUS, 32'h0);
        check(r, 32'h0000_0432);
        finish_task();
        wait_load();
        check({active_task, pc_load_value}, {4'h3, 16'ha003});
        finish_task();
        wait_load();
        check({bg_running, active_task, pc_load_value}, {5'h18, rp});
    endtask

    task automatic s_region();
        @(posedge pclk);
        no_preempt_region <= 1'h1;
        trig(8'h01);
        tick(6);
        check({bg_running, active_task}, 5'h18);
        @(posedge pclk);
        no_preempt_region <= 1'h0;
        wait_load();
        check({active_task, pc_load_value}, {4'h1, 16'ha001});
        finish_task();
        wait_load();
        check(bg_running, 1'h1);
        @(posedge pclk);
        bg_terminate <= 1'h1;
        @(posedge pclk);
        bg_terminate <= 1'h0;
        tick(2);
        check({bg_running, active_task}, 5'h00);
    endtask

    task automatic s_retire();
        trig(8'h80);
        wait_load();
        trig(8'h80);
        apb(1'h0, OFS_STATUS, 32'h0);
        check(r, 32'h0000_8018);
        apb(1'h1, OFS_BG_CTRL, 32'h3);
        wait_load();
        check({bg_running, active_task, pc_load_value}, {5'h18, 16'ha009});
        trig(8'h01);
        wait_load();
        check({bg_running, active_task}, 5'h01);
        @(posedge pclk);
        bg_terminate <= 1'h1;
        @(posedge pclk);
        bg_terminate <= 1'h0;
        finish_task();
        tick(4);
        check({bg_running, active_task}, 5'h00);
        apb(1'h0, OFS_STATUS, 32'h0);
        check(r, 32'h0);
    endtask

    task automatic s_conv();
        @(posedge pclk);
        conv_done <= 1'h1;
        conv_result <= 16'h5a3c;
        @(negedge pclk);
        check(result_data, 16'h5a3c);
        @(posedge pclk);
        conv_done <= 1'h0;
        apb(1'h0, OFS_RESULT, 32'h0);
        check(r, 32'h5a3c);
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'h0;
        forever #10 pclk = ~pclk;
    end

    initial begin
        #200000;
        mismatches++;
        wrap_up();
    end

    initial begin
        {presetn, psel, penable, pwrite, bg_terminate, no_preempt_region} = 6'h00;
        {fin, conv_done, paddr, pwdata, task_trigger, conv_result} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        s_regs();
        s_plain();
        s_background();
        s_region();
        s_retire();
        s_conv();
        wrap_up();
    end
endmodule // accel_background_task_scheduler_test
`default_nettype wire

/* tb/accel_core_model.sv */
// Accelerator core model: program counter and task end pulse.
// Assumes the bench asks for a task end through finish.
`timescale 1ns/1ns
`default_nettype none
module accel_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pc_load,
    input wire logic [15:0] pc_load_value,
    input wire logic finish,
    output logic [15:0] accel_pc,
    output logic task_done
);
    // Counter jumps on each load, then steps every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accel_pc <= 16'h0000;
            task_done <= 1'h0;
        end else begin
            accel_pc <= pc_load ? pc_load_value : accel_pc + 16'h0001;
            task_done <= finish;
        end
    end
endmodule // accel_core_model
`default_nettype wire

/* tb/sched_props.sv */
// Port assertions for the background task scheduler.
// Assumes a single pclk domain; bound to every scheduler instance.
`timescale 1ns/1ns
`default_nettype none
module sched_props #(
    parameter int RESULT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [sched_pkg::PADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] task_trigger,
    input wire logic task_done,
    input wire logic bg_terminate,
    input wire logic no_preempt_region,
    input wire logic pc_load,
    input wire logic task_start,
    input wire logic [3:0] active_task,
    input wire logic bg_running,
    input wire logic conv_done,
    input wire logic [RESULT_W-1:0] conv_result,
    input wire logic [RESULT_W-1:0] result_data
);
    import sched_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_const: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (
        psel && penable && paddr > OFS_RESULT |-> pslverr) else $error("no error");
    a_result_bypass: assert property (
        conv_done |-> result_data == conv_result) else $error("result not bypassed");
    a_region_blocks: assert property (
        bg_running && no_preempt_region |=> !task_start) else $error("region preempted");
    a_preempt_prompt: assert property (
        bg_running && !no_preempt_region && (|task_trigger[6:0])
        ##1 (bg_running && !no_preempt_region) |=> task_start) else $error("no preempt");
    a_bg_is_task8: assert property (
        bg_running |-> active_task == 4'h8) else $error("background not task 8");
    a_bg_persists: assert property (
        bg_running && no_preempt_region && !task_done && !bg_terminate && !psel
        |=> bg_running) else $error("background stopped");
    a_term_ends: assert property (
        bg_running && bg_terminate |=> !bg_running) else $error("terminate ignored");
    a_resume_load: assert property (
        $rose(bg_running) |-> pc_load) else $error("no pc load on resume");
    a_start_loads: assert property (
        task_start |-> pc_load && active_task inside {[4'h1:4'h8]}) else $error("bad start");
endmodule // sched_props

bind accel_background_task_scheduler sched_props #(.RESULT_W(RESULT_W)) props_u (
    .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .task_trigger,
    .task_done, .bg_terminate, .no_preempt_region, .pc_load, .task_start,
    .active_task, .bg_running, .conv_done, .conv_result, .result_data
);
`default_nettype wire
